// file: logic/scc_clock_ctrl.sv
`timescale 1ns/1ps
// Function
// - Mode comes from three-bit fuse field
// - Eight oscillator modes decoded from fuses
// - RC mode drives input clock over four
// - External clock drives output over four
// - RC I/O mode hands pin to port
// - External I/O mode hands pin to port
// - External clock modes skip start-up delay
// - PLL multiplies crystal frequency by four
// - PLL only in high-speed PLL mode
// - Lock timer holds core until locked
// - Switching needs enable fuse programmed zero
// - Select bit zero main, one secondary
// - Every reset clears select bit
// - Secondary disabled forces select bit clear
// - Eight target rising edges before use
// - Freeze at Q1, resume after eight
// - Crystal return adds start-up time too
// - Sleep stops clocks, holds at Q1
// - Wake on reset, watchdog or interrupt
// - Power-up delay only after power/brown-out
// - Start-up timer holds until crystal stable
// - Reset, power-up, start-up, then PLL lock
// - Start-up timer counts 1024 input edges
// - Sleep kills feedback, drives RC/EC low
module scc_clock_ctrl #(
  parameter int POWERUP_TIMER_CYCLES = scc_pkg::POWERUP_TIMER_CYC,
  parameter int PLL_CYCLES = scc_pkg::PLL_LOCK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scc_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [scc_pkg::APB_DATA_W-1:0] pwdata,
  output logic pready,
  output logic [scc_pkg::APB_DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic [2:0] osc_mode_fuses,
  input wire logic switch_enable_fuse,
  input wire logic powerup_timer_disable_fuse,
  input wire logic secondary_osc_enable,
  input wire logic por_event,
  input wire logic brown_out_reset,
  input wire logic ext_reset,
  input wire logic wdt_reset,
  input wire logic sleep_req,
  input wire logic wake_irq,
  input wire logic osc_in_pin,
  input wire logic sec_osc_pin,
  input wire logic osc_out_pin_i,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  input wire logic port_a_bit_six_out,
  input wire logic port_a_bit_six_oe,
  output logic port_a_bit_six_in,
  output logic feedback_enable,
  output logic pll_enable,
  output logic [2:0] pll_mult,
  output logic sys_clk_out,
  output logic core_run,
  output logic first_quarter_phase,
  output logic device_in_reset
);
  import scc_pkg::*;

  // One counter serves every timer, so it must cover the longest of them
  localparam int CNT_W = $clog2(((POWERUP_TIMER_CYCLES > OST_EDGES) ? POWERUP_TIMER_CYCLES : OST_EDGES) + PLL_CYCLES + 1);

  typedef struct packed {
    scc_state_t st;
    logic [1:0] in_s;
    logic [1:0] sec_s;
    logic in_d;
    logic sec_d;
    logic sel;
    logic src_sec;
    logic tgt_sec;
    logic sw_pend;
    logic sleep_pend;
    logic powerup_timer_pend;
    logic [1:0] phase;
    logic [1:0] div;
    logic [CNT_W-1:0] cnt;
    logic clk_out;
    logic pin_o;
    logic pin_oe;
    logic [APB_DATA_W-1:0] rdata;
    logic slverr;
  } scc_regs_t;

  scc_regs_t cur_ff;
  scc_regs_t nxt_ff;

  scc_osc_mode_t mode;
  logic is_xtal;
  logic is_pll;
  logic is_io;
  logic in_rise;
  logic sec_rise;
  logic src_rise;
  logic tgt_rise;
  logic sw_allowed;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic [APB_DATA_W-1:0] stat_word;

  assign mode = scc_osc_mode_t'(osc_mode_fuses);
  assign is_xtal = (mode == OSC_LOW_POWER_CRYSTAL) || (mode == OSC_CRYSTAL) ||
                   (mode == OSC_HIGH_SPEED) || (mode == OSC_HIGH_SPEED_PLL);
  assign is_pll = (mode == OSC_HIGH_SPEED_PLL);
  assign is_io = (mode == OSC_RES_CAP_IO) || (mode == OSC_EXT_CLOCK_IO);

  // Edges seen only after two synchroniser stages
  assign in_rise = cur_ff.in_s[1] & ~cur_ff.in_d;
  assign sec_rise = cur_ff.sec_s[1] & ~cur_ff.sec_d;
  assign src_rise = cur_ff.src_sec ? sec_rise : in_rise;
  assign tgt_rise = cur_ff.tgt_sec ? sec_rise : in_rise;
  assign sw_allowed = ~switch_enable_fuse & secondary_osc_enable;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_ctrl = (paddr == OSC_CTRL_ADDR);
  assign hit_stat = (paddr == OSC_STAT_ADDR);

  always_comb begin
    stat_word = '0;
    stat_word[STAT_SRC_SEC_BIT] = cur_ff.src_sec;
    stat_word[STAT_CORE_RUN_BIT] = (cur_ff.st == ST_RUN);
    stat_word[STAT_PLL_BIT] = is_pll;
    stat_word[STAT_SLEEP_BIT] = (cur_ff.st == ST_SLEEP);
    stat_word[STAT_MODE_LSB +: 3] = osc_mode_fuses;
  end

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.in_s = {cur_ff.in_s[0], osc_in_pin};
    nxt_ff.sec_s = {cur_ff.sec_s[0], sec_osc_pin};
    nxt_ff.in_d = cur_ff.in_s[1];
    nxt_ff.sec_d = cur_ff.sec_s[1];

    // Divider runs off synchronised main input edges, independent of the selected source
    if (in_rise) begin
      nxt_ff.div = cur_ff.div + 2'h1;
    end

    // Quarter phase advances only while the core clock runs
    if ((cur_ff.st == ST_RUN || cur_ff.st == ST_FREEZE_WAIT) && src_rise) begin
      nxt_ff.phase = cur_ff.phase + 2'h1;
    end

    // Register access; read data captured in setup so it stands in access
    if (setup) begin
      nxt_ff.slverr = ~(hit_ctrl | hit_stat);
      nxt_ff.rdata = '0;
      if (hit_ctrl) begin
        nxt_ff.rdata[CTRL_SEL_BIT] = cur_ff.sel;
      end else if (hit_stat) begin
        nxt_ff.rdata = stat_word;
      end
    end
    if (access && pwrite && hit_ctrl) begin
      nxt_ff.sel = pwdata[CTRL_SEL_BIT] & sw_allowed;
    end
    if (!sw_allowed) begin
      nxt_ff.sel = 1'b0;
    end

    if (sleep_req && cur_ff.st == ST_RUN) begin
      nxt_ff.sleep_pend = 1'b1;
    end

    case (cur_ff.st)
      ST_RESET_DELAY: begin
        nxt_ff.cnt = cur_ff.cnt + 1'b1;
        if (cur_ff.cnt == CNT_W'(RESET_DELAY_CYC - 1)) begin
          nxt_ff.cnt = '0;
          if (cur_ff.powerup_timer_pend) begin
            nxt_ff.st = ST_POWERUP;
          end else if (is_xtal) begin
            nxt_ff.st = ST_OSC_START;
          end else begin
            nxt_ff.st = ST_RUN;
          end
        end
      end
      ST_POWERUP: begin
        nxt_ff.cnt = cur_ff.cnt + 1'b1;
        if (cur_ff.cnt == CNT_W'(POWERUP_TIMER_CYCLES - 1)) begin
          nxt_ff.cnt = '0;
          nxt_ff.powerup_timer_pend = 1'b0;
          nxt_ff.st = is_xtal ? ST_OSC_START : ST_RUN;
        end
      end
      ST_OSC_START: begin
        // Edges of the input pin prove the crystal is swinging
        if (in_rise) begin
          nxt_ff.cnt = cur_ff.cnt + 1'b1;
          if (cur_ff.cnt == CNT_W'(OST_EDGES - 1)) begin
            nxt_ff.cnt = '0;
            if (is_pll) begin
              nxt_ff.st = ST_PLL_LOCK;
            end else begin
              nxt_ff.st = cur_ff.sw_pend ? ST_SYNC : ST_RUN;
            end
          end
        end
      end
      ST_PLL_LOCK: begin
        nxt_ff.cnt = cur_ff.cnt + 1'b1;
        if (cur_ff.cnt == CNT_W'(PLL_CYCLES - 1)) begin
          nxt_ff.cnt = '0;
          nxt_ff.st = cur_ff.sw_pend ? ST_SYNC : ST_RUN;
        end
      end
      ST_RUN: begin
        if (cur_ff.sleep_pend && cur_ff.phase == PHASE_Q1) begin
          nxt_ff.sleep_pend = 1'b0;
          nxt_ff.st = ST_SLEEP;
        end else if ((cur_ff.sel & sw_allowed) != cur_ff.src_sec) begin
          nxt_ff.tgt_sec = cur_ff.sel & sw_allowed;
          nxt_ff.st = ST_FREEZE_WAIT;
        end
      end
      ST_FREEZE_WAIT: begin
        // Freeze only on the last quarter edge, so the core stops at Q1
        if (src_rise && cur_ff.phase == PHASE_LAST) begin
          nxt_ff.cnt = '0;
          if (!cur_ff.tgt_sec && is_xtal) begin
            nxt_ff.sw_pend = 1'b1;
            nxt_ff.st = ST_OSC_START;
          end else begin
            nxt_ff.st = ST_SYNC;
          end
        end
      end
      ST_SYNC: begin
        if (tgt_rise) begin
          nxt_ff.cnt = cur_ff.cnt + 1'b1;
          if (cur_ff.cnt == CNT_W'(SYNC_EDGES - 1)) begin
            nxt_ff.cnt = '0;
            nxt_ff.src_sec = cur_ff.tgt_sec;
            nxt_ff.sw_pend = 1'b0;
            nxt_ff.phase = PHASE_Q1;
            nxt_ff.st = ST_RUN;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_irq) begin
          nxt_ff.cnt = '0;
          nxt_ff.st = is_xtal ? ST_OSC_START : ST_RUN;
        end
      end
      default: begin
        nxt_ff.st = ST_RESET_DELAY;
        nxt_ff.cnt = '0;
      end
    endcase

    // Warm resets restart on the main source without the power-up delay
    if (ext_reset || wdt_reset) begin
      nxt_ff.sel = 1'b0;
      nxt_ff.src_sec = 1'b0;
      nxt_ff.tgt_sec = 1'b0;
      nxt_ff.sw_pend = 1'b0;
      nxt_ff.sleep_pend = 1'b0;
      nxt_ff.phase = PHASE_Q1;
      nxt_ff.cnt = '0;
      if (cur_ff.st == ST_SLEEP && is_xtal) begin
        nxt_ff.st = ST_OSC_START;
      end else if (cur_ff.st == ST_SLEEP || cur_ff.st == ST_RUN ||
                   cur_ff.st == ST_FREEZE_WAIT || cur_ff.st == ST_SYNC) begin
        nxt_ff.st = ST_RUN;
      end else begin
        nxt_ff.st = cur_ff.st;
      end
    end

    // Power-on and brown-out rerun the whole sequence
    if (por_event || brown_out_reset) begin
      nxt_ff.sel = 1'b0;
      nxt_ff.src_sec = 1'b0;
      nxt_ff.tgt_sec = 1'b0;
      nxt_ff.sw_pend = 1'b0;
      nxt_ff.sleep_pend = 1'b0;
      nxt_ff.phase = PHASE_Q1;
      nxt_ff.cnt = '0;
      nxt_ff.powerup_timer_pend = ~powerup_timer_disable_fuse;
      nxt_ff.st = ST_RESET_DELAY;
    end

    // Clock held low outside run and freeze wait, so no partial pulse leaks out
    // Follows the next state, so the clock drops on the same edge as the run state
    if (nxt_ff.st == ST_RUN || nxt_ff.st == ST_FREEZE_WAIT) begin
      nxt_ff.clk_out = cur_ff.src_sec ? cur_ff.sec_s[1] : cur_ff.in_s[1];
    end else begin
      nxt_ff.clk_out = 1'b0;
    end

    // Oscillator output pin role
    if (is_xtal) begin
      nxt_ff.pin_oe = 1'b0;
      nxt_ff.pin_o = 1'b0;
    end else if (is_io) begin
      nxt_ff.pin_oe = port_a_bit_six_oe;
      nxt_ff.pin_o = port_a_bit_six_out;
    end else if (cur_ff.st == ST_SLEEP) begin
      nxt_ff.pin_oe = 1'b1;
      nxt_ff.pin_o = 1'b0;
    end else begin
      nxt_ff.pin_oe = 1'b1;
      nxt_ff.pin_o = cur_ff.div[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff.st <= ST_RESET_DELAY;
      cur_ff.in_s <= 2'h0;
      cur_ff.sec_s <= 2'h0;
      cur_ff.in_d <= 1'b0;
      cur_ff.sec_d <= 1'b0;
      cur_ff.sel <= OSC_CTRL_RST[CTRL_SEL_BIT];
      cur_ff.src_sec <= 1'b0;
      cur_ff.tgt_sec <= 1'b0;
      cur_ff.sw_pend <= 1'b0;
      cur_ff.sleep_pend <= 1'b0;
      // Hardware reset counts as power-on; the fuse is applied once out of reset
      cur_ff.powerup_timer_pend <= 1'b1;
      cur_ff.phase <= PHASE_Q1;
      cur_ff.div <= DIV_RST;
      cur_ff.cnt <= '0;
      cur_ff.clk_out <= 1'b0;
      cur_ff.pin_o <= 1'b0;
      cur_ff.pin_oe <= 1'b0;
      cur_ff.rdata <= '0;
      cur_ff.slverr <= 1'b0;
    end else begin
      cur_ff <= nxt_ff;
      if (cur_ff.st == ST_RESET_DELAY && cur_ff.cnt == '0 && !por_event && !brown_out_reset) begin
        cur_ff.powerup_timer_pend <= nxt_ff.powerup_timer_pend & ~powerup_timer_disable_fuse;
      end
    end
  end

  assign pready = 1'b1;
  assign prdata = cur_ff.rdata;
  assign pslverr = cur_ff.slverr & access;

  assign osc_out_pin_o = cur_ff.pin_o;
  assign osc_out_pin_oe = cur_ff.pin_oe;
  assign port_a_bit_six_in = osc_out_pin_i;
  // Feedback inverter only for crystals, and off in sleep
  assign feedback_enable = is_xtal && cur_ff.st != ST_SLEEP;
  assign pll_enable = is_pll && cur_ff.st != ST_SLEEP;
  assign pll_mult = is_pll ? 3'(PLL_MULT) : 3'h1;
  assign sys_clk_out = cur_ff.clk_out;
  assign core_run = (cur_ff.st == ST_RUN);
  assign first_quarter_phase = (cur_ff.phase == PHASE_Q1);
  assign device_in_reset = (cur_ff.st == ST_RESET_DELAY) || (cur_ff.st == ST_POWERUP) ||
                           ((cur_ff.st == ST_OSC_START || cur_ff.st == ST_PLL_LOCK) && !cur_ff.sw_pend);
endmodule : scc_clock_ctrl

// file: common/scc_pkg.sv
package scc_pkg;
  // Bus geometry
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  // Register byte addresses
  localparam logic [APB_ADDR_W-1:0] OSC_CTRL_ADDR = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OSC_STAT_ADDR = 12'h004;
  localparam int OSC_CTRL_W = 8;
  localparam logic [OSC_CTRL_W-1:0] OSC_CTRL_RST = 8'h00;
  // Field positions
  localparam int CTRL_SEL_BIT = 0;
  localparam int STAT_SRC_SEC_BIT = 0;
  localparam int STAT_CORE_RUN_BIT = 1;
  localparam int STAT_PLL_BIT = 2;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_MODE_LSB = 4;
  // Clock and times
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int POWERUP_TIMER_TIME_MS = 72;
  localparam int PLL_LOCK_TIME_MS = 2;
  localparam int POWERUP_TIMER_CYC = POWERUP_TIMER_TIME_MS * CLK_FREQ_KHZ;
  localparam int PLL_LOCK_CYC = PLL_LOCK_TIME_MS * CLK_FREQ_KHZ;
  localparam int RESET_DELAY_CYC = 16;
  // Edge counts, PLL factor, phase and divider values
  localparam int OST_EDGES = 1024;
  localparam int SYNC_EDGES = 8;
  localparam int PLL_MULT = 4;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] DIV_RST = 2'h0;

  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL,
    OSC_CRYSTAL,
    OSC_HIGH_SPEED,
    OSC_HIGH_SPEED_PLL,
    OSC_RES_CAP,
    OSC_RES_CAP_IO,
    OSC_EXT_CLOCK,
    OSC_EXT_CLOCK_IO
  } scc_osc_mode_t;

  typedef enum logic [3:0] {
    ST_RESET_DELAY,
    ST_POWERUP,
    ST_OSC_START,
    ST_PLL_LOCK,
    ST_RUN,
    ST_FREEZE_WAIT,
    ST_SYNC,
    ST_SLEEP
  } scc_state_t;
endpackage : scc_pkg

// file: sim/scc_osc_src.sv
`timescale 1ns/1ps
module scc_osc_src #(
  parameter int MAIN_HALF = 4,
  parameter int SEC_HALF = 8
) (
  input wire logic pclk,
  input wire logic [2:0] osc_mode_fuses,
  input wire logic feedback_enable,
  output logic osc_in_pin,
  output logic sec_osc_pin
);
  int cm = 0;
  int cs = 0;
  initial osc_in_pin = 1'b0;
  initial sec_osc_pin = 1'b0;
  // Crystal stalls with its inverter off; driven sources run free
  always @(posedge pclk) begin
    if (feedback_enable || osc_mode_fuses > 3'h3) begin
      cm <= (cm == MAIN_HALF - 1) ? 0 : cm + 1;
      if (cm == MAIN_HALF - 1) osc_in_pin <= !osc_in_pin;
    end
    cs <= (cs == SEC_HALF - 1) ? 0 : cs + 1;
    if (cs == SEC_HALF - 1) sec_osc_pin <= !sec_osc_pin;
  end
endmodule : scc_osc_src

// file: sim/scc_clock_ctrl_assertions.sv
`timescale 1ns/1ps
module scc_clock_ctrl_assertions #(
  parameter int POWERUP_TIMER_CYCLES = 64,
  parameter int PLL_CYCLES = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] osc_mode_fuses,
  input wire logic powerup_timer_disable_fuse,
  input wire logic osc_out_pin_i,
  input wire logic port_a_bit_six_oe,
  input wire logic osc_out_pin_oe,
  input wire logic port_a_bit_six_in,
  input wire logic feedback_enable,
  input wire logic pll_enable,
  input wire logic [2:0] pll_mult,
  input wire logic sys_clk_out,
  input wire logic core_run,
  input wire logic device_in_reset
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pll_only_hs: assert property (pll_enable |-> osc_mode_fuses == 3'h3) else $error("pll outside pll mode");
  a_pll_times_four: assert property (pll_mult == ((osc_mode_fuses == 3'h3) ? 3'h4 : 3'h1))
    else $error("pll factor wrong");
  a_pin_to_port: assert property (osc_mode_fuses inside {3'h5, 3'h7} && $stable(osc_mode_fuses)
    |-> osc_out_pin_oe == $past(port_a_bit_six_oe) && port_a_bit_six_in == osc_out_pin_i)
    else $error("pin not handed to port");
  a_div_out_drive: assert property (osc_mode_fuses inside {3'h4, 3'h6} && $stable(osc_mode_fuses) && core_run
    |-> osc_out_pin_oe)
    else $error("divided clock not driven");
  a_fb_crystal_only: assert property (feedback_enable |-> osc_mode_fuses < 3'h4) else $error("feedback on");
  a_run_after_reset: assert property (core_run |-> !device_in_reset) else $error("core runs in reset");
  a_reset_delay_held: assert property ($rose(presetn) |-> device_in_reset [*8]) else $error("delay short");
  a_ext_no_startup: assert property ($rose(presetn) && osc_mode_fuses > 3'h5 && powerup_timer_disable_fuse
    |-> ##[1:24] !device_in_reset) else $error("start-up delay in ext mode");
  a_clk_held_low: assert property (device_in_reset |-> !sys_clk_out) else $error("clock out in reset");
  cover property ($rose(core_run));
  cover property (pll_enable && core_run);
  cover property (core_run && osc_mode_fuses == 3'h4);
endmodule : scc_clock_ctrl_assertions

bind scc_clock_ctrl scc_clock_ctrl_assertions #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES), .PLL_CYCLES(PLL_CYCLES)) scc_chk (
  .pclk, .presetn, .osc_mode_fuses, .powerup_timer_disable_fuse, .osc_out_pin_i, .port_a_bit_six_oe, .osc_out_pin_oe,
  .port_a_bit_six_in, .feedback_enable, .pll_enable, .pll_mult, .sys_clk_out, .core_run, .device_in_reset);

// file: sim/system_clock_source_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s exp %0h got %0h", nm, (e), (g)); end end
module system_clock_source_control_tb_top;
  import scc_pkg::*;
  localparam int PW = 64;
  localparam int PL = 32;
  localparam int MH = 4;
  localparam int SH = 8;
  localparam int OSTC = OST_EDGES * 2 * MH;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic [APB_DATA_W-1:0] pwdata = '0, prdata;
  logic [2:0] osc_mode_fuses = 3'h6, pll_mult;
  logic switch_enable_fuse = 1'b0, powerup_timer_disable_fuse = 1'b1, secondary_osc_enable = 1'b0;
  logic por_event = 1'b0, brown_out_reset = 1'b0, ext_reset = 1'b0, wdt_reset = 1'b0;
  logic sleep_req = 1'b0, wake_irq = 1'b0, port_a_bit_six_out = 1'b0, port_a_bit_six_oe = 1'b0;
  logic pready, pslverr, osc_in_pin, sec_osc_pin, osc_out_pin_i, osc_out_pin_o, osc_out_pin_oe;
  logic port_a_bit_six_in, feedback_enable, pll_enable, sys_clk_out, core_run, first_quarter_phase, device_in_reset;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  // Pulled high when nobody drives the pin
  assign osc_out_pin_i = osc_out_pin_oe ? osc_out_pin_o : port_a_bit_six_oe ? port_a_bit_six_out : 1'b1;
  scc_clock_ctrl #(.POWERUP_TIMER_CYCLES(PW), .PLL_CYCLES(PL)) scc_clock_ctrl_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .osc_mode_fuses,
    .switch_enable_fuse, .powerup_timer_disable_fuse, .secondary_osc_enable, .por_event, .brown_out_reset,
    .ext_reset, .wdt_reset, .sleep_req, .wake_irq, .osc_in_pin, .sec_osc_pin, .osc_out_pin_i, .osc_out_pin_o,
    .osc_out_pin_oe, .port_a_bit_six_out, .port_a_bit_six_oe, .port_a_bit_six_in, .feedback_enable, .pll_enable,
    .pll_mult, .sys_clk_out, .core_run, .first_quarter_phase, .device_in_reset);
  scc_osc_src #(.MAIN_HALF(MH), .SEC_HALF(SH)) scc_osc_src_inst (.pclk, .osc_mode_fuses, .feedback_enable,
    .osc_in_pin, .sec_osc_pin);
  initial begin
    forever #25 pclk = ~pclk;
  end
  task automatic final_report();
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    r = prdata;
    `CHK("pslverr", a > 12'h004, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bounded wait on the run flag
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_run !== v && n < 20000);
  endtask : wait_lvl
  task automatic boot(input logic [2:0] m, input logic pd, output int n);
    @(posedge pclk);
    osc_mode_fuses <= m;
    powerup_timer_disable_fuse <= pd;
    por_event <= 1'b1;
    @(posedge pclk);
    por_event <= 1'b0;
    wait_lvl(1'b0, n);
    `CHK("in_reset", 1'b1, device_in_reset)
    wait_lvl(1'b1, n);
  endtask : boot
  task automatic t_sleep();
    int n;
    @(posedge pclk);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    wait_lvl(1'b0, n);
    repeat (20) @(posedge pclk);
    `CHK("q1", 1'b1, first_quarter_phase)
    `CHK("out_low", 1'b0, osc_out_pin_o)
    `CHK("asleep", 1'b0, core_run)
    wake_irq <= 1'b1;
    @(posedge pclk);
    wake_irq <= 1'b0;
    wait_lvl(1'b1, n);
    `CHK("ec_wake", 1'b1, n < 40)
    powerup_timer_disable_fuse <= 1'b0;
    brown_out_reset <= 1'b1;
    @(posedge pclk);
    brown_out_reset <= 1'b0;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    `CHK("bor_powerup_timer", 1'b1, n >= RESET_DELAY_CYC + PW - 8)
  endtask : t_sleep
  task automatic t_modes();
    int n, lo, e;
    logic [2:0] m;
    logic last;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      boot(m, m[0], n);
      lo = RESET_DELAY_CYC + (m[0] ? 0 : PW) + (m < 3'h4 ? OSTC : 0) + (m == 3'h3 ? PL : 0);
      `CHK("boot_min", 1'b1, n >= lo - 24)
      `CHK("boot_max", 1'b1, n <= lo + 32)
      `CHK("pll_en", m == 3'h3, pll_enable)
      `CHK("pll_mult", (m == 3'h3) ? 3'h4 : 3'h1, pll_mult)
      `CHK("fb_en", m < 3'h4, feedback_enable)
      `CHK("out_oe", m == 3'h4 || m == 3'h6, osc_out_pin_oe)
      e = 0;
      last = osc_out_pin_o;
      repeat (256) begin
        @(posedge pclk);
        if (osc_out_pin_o !== last) e++;
        last = osc_out_pin_o;
      end
      if (!m[0] && m[2]) `CHK("div4", 1'b1, e >= 15 && e <= 17)
      if (m[0] && m[2]) begin
        port_a_bit_six_oe <= 1'b1;
        for (int v = 0; v < 2; v++) begin
          port_a_bit_six_out <= v[0];
          repeat (2) @(posedge pclk);
          `CHK("pa6_in", v[0], port_a_bit_six_in)
        end
        port_a_bit_six_oe <= 1'b0;
      end
    end
  endtask : t_modes
  task automatic t_switch();
    int n;
    logic [31:0] r;
    boot(3'h2, 1'b1, n);
    apb(1'b0, 12'h008, 32'h0, r);
    apb(1'b1, OSC_STAT_ADDR, 32'hFF, r);
    apb(1'b0, OSC_STAT_ADDR, 32'h0, r);
    `CHK("stat_mode", 3'h2, r[6:4])
    switch_enable_fuse <= 1'b1;
    secondary_osc_enable <= 1'b1;
    apb(1'b1, OSC_CTRL_ADDR, 32'h1, r);
    apb(1'b0, OSC_CTRL_ADDR, 32'h0, r);
    `CHK("sel_fuse_off", 1'b0, r[0])
    switch_enable_fuse <= 1'b0;
    secondary_osc_enable <= 1'b0;
    apb(1'b1, OSC_CTRL_ADDR, 32'h1, r);
    apb(1'b0, OSC_CTRL_ADDR, 32'h0, r);
    `CHK("sel_sec_off", 1'b0, r[0])
    secondary_osc_enable <= 1'b1;
    apb(1'b1, OSC_CTRL_ADDR, 32'h1, r);
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    `CHK("to_sec", 1'b1, n >= 7 * 2 * SH && n <= 240)
    apb(1'b0, OSC_STAT_ADDR, 32'h0, r);
    `CHK("on_sec", 1'b1, r[STAT_SRC_SEC_BIT])
    apb(1'b1, OSC_CTRL_ADDR, 32'h0, r);
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    `CHK("to_main", 1'b1, n >= OSTC)
    apb(1'b1, OSC_CTRL_ADDR, 32'h1, r);
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wdt_reset <= 1'b1;
    @(posedge pclk);
    wdt_reset <= 1'b0;
    apb(1'b0, OSC_CTRL_ADDR, 32'h0, r);
    `CHK("sel_reset", 1'b0, r[0])
    wait_lvl(1'b1, n);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    wait_lvl(1'b0, n);
    repeat (4) @(posedge pclk);
    `CHK("fb_sleep", 1'b0, feedback_enable)
    ext_reset <= 1'b1;
    @(posedge pclk);
    ext_reset <= 1'b0;
    wait_lvl(1'b1, n);
    `CHK("xtal_wake", 1'b1, n >= OSTC - 24)
  endtask : t_switch
  initial begin
    int n;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_lvl(1'b1, n);
    t_sleep();
    t_modes();
    t_switch();
    final_report();
  end
endmodule : system_clock_source_control_tb_top
